// File: snp_pkg.sv
package snp_pkg;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_SOFT_SAVE = 8'h3c;
    localparam logic [7:0] OP_SOFT_RESTORE = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;
    localparam logic [7:0] OP_RESERVED = 8'h1e;

    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_GUARD_LO = 2;
    localparam int BIT_GUARD_HI = 3;
    localparam int BIT_PIN_GUARD = 7;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hfc;
    localparam logic [7:0] STATUS_NV_MASK = 8'h8c;
    localparam logic [2:0] VOLATILE_RESET = 3'h0;

    localparam int ADDR_W = 17;
    localparam logic [16:0] QUARTER_BASE = 17'h18000;
    localparam logic [16:0] HALF_BASE = 17'h10000;

    localparam int SYNC_STAGES = 3;

    typedef enum {
        SNP_IDLE, SNP_OPCODE, SNP_STATUS_OUT, SNP_STATUS_IN, SNP_ADDR, SNP_READ,
        SNP_WRITE, SNP_IGNORE
    } snp_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic strobe;
    } snp_mem_wr_s;

    typedef struct packed {
        logic save;
        logic restore;
        logic autosaveOn;
        logic autosaveOff;
    } snp_nv_cmd_s;
endpackage

// File: snp_pin_sync.sv
`timescale 1ns/100ps
module snp_pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    always_comb begin
        next_level = level;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_level[i] = stage2[i];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            level <= INIT;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end
endmodule // snp_pin_sync

// File: snp_nvram_cmd_protect.sv
// What this block does
// [RULE_01] Opcodes land in an 8-bit register; all bytes move most significant bit first.
// [RULE_02] Master opens each instruction with falling chip select; first byte is opcode.
// [RULE_03] Decode 06 set latch, 04 clear latch, 05 read status, 01 write status.
// [RULE_04] Ten instructions: 03 reads array, 02 writes array, 1e is reserved.
// [RULE_05] Decode 3c save, 60 restore, 59 autosave on, 19 autosave off.
// [RULE_06] Status: busy bit 0, latch bit 1, guards bits 2-3, spare 4-6, pin enable 7.
// [RULE_07] Busy reads one while a save or software restore runs.
// [RULE_08] Status write changes only bits 2-7; busy and latch untouched.
// [RULE_09] Spare bits 4-6 are volatile, writable, and zero after power-up.
// [RULE_10] Master should send zeros in bits 4-6 when writing status.
// [RULE_11] Status write is opcode then exactly eight data bits, captured into the register.
// [RULE_12] Master sets the latch before a status write, else it has no effect.
// [RULE_13] Written status becomes nonvolatile only after a later save completes.
// [RULE_14] Write-guard pin matters only while the pin enable bit is one.
// [RULE_15] Memory write, status write and nonvolatile commands need the latch set.
// [RULE_16] With latch clear, write commands are ignored until the next chip select.
// [RULE_17] Set-latch command sets the latch; latch is zero after power-up.
// [RULE_18] Completed write-type commands clear the latch automatically.
// [RULE_19] Clear-latch command clears the latch when chip select rises.
// [RULE_20] Status read shifts out the current status contents.
// [RULE_21] Guards: 00 none, 01 top quarter, 10 top half, 11 whole array.
// [RULE_22] Protected addresses may be read but never written.
// [RULE_23] Unknown opcode: ignore input until next chip select, output stays undriven.
// [RULE_24] Pin low with pin enable set refuses every status write.
// [RULE_25] Burst write through protected space keeps counting, writes nothing, resumes after.
`timescale 1ns/100ps
module snp_nvram_cmd_protect #(
    parameter int ADDR_BYTES = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic writeGuardN,
    output logic spiMiso,
    output logic spiMisoOe,
    input wire logic nvBusy,
    input wire logic [7:0] nvStatusImage,
    input wire logic nvStatusLoad,
    output logic [7:0] statusNvCopy,
    output snp_pkg::snp_nv_cmd_s nvCmd,
    output snp_pkg::snp_mem_wr_s memWr,
    output logic [snp_pkg::ADDR_W-1:0] memRdAddr,
    output logic memRdReq,
    input wire logic [7:0] memRdData,
    output logic hwSaveBusyPin
);
    // The byte counter is two bits wide, so more than four address bytes cannot be counted
    if (ADDR_BYTES * 8 < snp_pkg::ADDR_W || ADDR_BYTES > 4) begin : g_addr_bytes_check
        $error("ADDR_BYTES cannot serve the address space");
    end

    logic [3:0] pinLevel;
    logic sck;
    logic csN;
    logic mosi;
    logic wgN;
    logic sckPrev;
    logic csPrev;

    snp_pin_sync #(.WIDTH(4), .INIT(4'ha)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pinIn({spiCsN, spiSck, spiMosi, writeGuardN}),
        .level(pinLevel)
    );

    assign csN = pinLevel[3];
    assign sck = pinLevel[2];
    assign mosi = pinLevel[1];
    assign wgN = pinLevel[0];

    wire csFall = csPrev && !csN;
    wire csRise = !csPrev && csN;
    wire sckRise = !csN && !sckPrev && sck;
    wire sckFall = !csN && sckPrev && !sck;

    function automatic logic guarded(input logic [1:0] guard, input logic [16:0] a);
        case (guard) // see [RULE_21]
            2'b00: guarded = 1'b0;
            2'b01: guarded = (a >= snp_pkg::QUARTER_BASE);
            2'b10: guarded = (a >= snp_pkg::HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction

    snp_pkg::snp_state_e state;
    snp_pkg::snp_state_e next_state;
    logic [7:0] shiftIn;
    logic [7:0] next_shiftIn;
    logic [2:0] bitCnt;
    logic [2:0] next_bitCnt;
    logic [1:0] byteCnt;
    logic [1:0] next_byteCnt;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [7:0] shiftOut;
    logic [7:0] next_shiftOut;
    logic [16:0] addr;
    logic [16:0] next_addr;
    logic latch;
    logic next_latch;
    logic clearAtRise;
    logic next_clearAtRise;
    logic [1:0] guard;
    logic [1:0] next_guard;
    logic pinGuard;
    logic next_pinGuard;
    logic [2:0] spare;
    logic [2:0] next_spare;
    logic wroteData;
    logic next_wroteData;
    logic misoOe;
    logic next_misoOe;
    logic miso;
    logic next_miso;
    snp_pkg::snp_nv_cmd_s next_nvCmd;
    snp_pkg::snp_mem_wr_s next_memWr;
    logic next_memRdReq;
    logic [16:0] next_memRdAddr;

    // see [RULE_06] [RULE_07]
    wire [7:0] statusNow = {pinGuard, spare, guard, latch, nvBusy};

    always_comb begin
        logic [7:0] byteIn;
        logic pinBlocks;
        byteIn = {shiftIn[6:0], mosi}; // see [RULE_01]
        pinBlocks = pinGuard && !wgN; // see [RULE_14]
        next_state = state;
        next_shiftIn = shiftIn;
        next_bitCnt = bitCnt;
        next_byteCnt = byteCnt;
        next_opcode = opcode;
        next_shiftOut = shiftOut;
        next_addr = addr;
        next_latch = latch;
        next_clearAtRise = clearAtRise;
        next_guard = guard;
        next_pinGuard = pinGuard;
        next_spare = spare;
        next_wroteData = wroteData;
        next_misoOe = misoOe;
        next_miso = miso;
        next_nvCmd = '0;
        next_memWr = memWr;
        next_memWr.strobe = 1'b0;
        next_memRdReq = 1'b0;
        next_memRdAddr = memRdAddr;
        if (nvStatusLoad) begin
            next_guard = nvStatusImage[snp_pkg::BIT_GUARD_HI:snp_pkg::BIT_GUARD_LO];
            next_pinGuard = nvStatusImage[snp_pkg::BIT_PIN_GUARD];
        end
        if (csRise || csN) begin
            next_state = snp_pkg::SNP_IDLE;
            next_misoOe = 1'b0;
            if (csRise && clearAtRise) begin
                next_latch = 1'b0; // see [RULE_18] [RULE_19]
            end
            if (csRise && wroteData) begin
                next_latch = 1'b0; // see [RULE_18]
            end
            if (csRise) begin
                next_clearAtRise = 1'b0;
                next_wroteData = 1'b0;
            end
        end else if (csFall) begin
            next_state = snp_pkg::SNP_OPCODE; // see [RULE_02]
            next_bitCnt = 3'h0;
            next_byteCnt = 2'h0;
        end else if (sckRise) begin
            next_shiftIn = byteIn;
            next_bitCnt = bitCnt + 3'h1;
            case (state)
                snp_pkg::SNP_OPCODE: begin
                    if (bitCnt == 3'h7) begin
                        next_opcode = byteIn;
                        next_state = snp_pkg::SNP_IGNORE;
                        // see [RULE_03] [RULE_04] [RULE_05] [RULE_15] [RULE_16] [RULE_23]
                        if (byteIn == snp_pkg::OP_SET_LATCH) begin
                            next_latch = 1'b1; // see [RULE_17]
                        end else if (byteIn == snp_pkg::OP_CLEAR_LATCH) begin
                            next_clearAtRise = 1'b1;
                        end else if (byteIn == snp_pkg::OP_STATUS_READ) begin
                            next_state = snp_pkg::SNP_STATUS_OUT; // see [RULE_20]
                            next_shiftOut = statusNow;
                        end else if (byteIn == snp_pkg::OP_STATUS_WRITE) begin
                            if (latch && !pinBlocks) begin // see [RULE_24]
                                next_state = snp_pkg::SNP_STATUS_IN;
                            end
                        end else if (byteIn == snp_pkg::OP_MEM_READ ||
                                     (byteIn == snp_pkg::OP_MEM_WRITE && latch)) begin
                            next_state = snp_pkg::SNP_ADDR;
                            next_byteCnt = 2'h0;
                        end else if (latch && byteIn == snp_pkg::OP_SOFT_SAVE) begin
                            next_nvCmd.save = 1'b1;
                            next_clearAtRise = 1'b1;
                        end else if (latch && byteIn == snp_pkg::OP_SOFT_RESTORE) begin
                            next_nvCmd.restore = 1'b1;
                            next_clearAtRise = 1'b1;
                        end else if (latch && byteIn == snp_pkg::OP_AUTOSAVE_ON) begin
                            next_nvCmd.autosaveOn = 1'b1;
                            next_clearAtRise = 1'b1;
                        end else if (latch && byteIn == snp_pkg::OP_AUTOSAVE_OFF) begin
                            next_nvCmd.autosaveOff = 1'b1;
                            next_clearAtRise = 1'b1;
                        end
                    end
                end
                snp_pkg::SNP_STATUS_IN: begin
                    if (bitCnt == 3'h7) begin
                        // see [RULE_08] [RULE_09] [RULE_11] [RULE_13]
                        next_guard = byteIn[snp_pkg::BIT_GUARD_HI:snp_pkg::BIT_GUARD_LO];
                        next_pinGuard = byteIn[snp_pkg::BIT_PIN_GUARD];
                        next_spare = byteIn[6:4];
                        next_wroteData = 1'b1;
                        next_state = snp_pkg::SNP_IGNORE;
                    end
                end
                snp_pkg::SNP_ADDR: begin
                    if (bitCnt == 3'h7) begin
                        next_addr = {addr[8:0], byteIn};
                        next_byteCnt = byteCnt + 2'h1;
                        if (byteCnt == 2'(ADDR_BYTES - 1)) begin
                            if (opcode == snp_pkg::OP_MEM_READ) begin
                                next_state = snp_pkg::SNP_READ;
                                next_memRdReq = 1'b1;
                                next_memRdAddr = {addr[8:0], byteIn};
                            end else begin
                                next_state = snp_pkg::SNP_WRITE;
                            end
                        end
                    end
                end
                snp_pkg::SNP_WRITE: begin
                    if (bitCnt == 3'h7) begin
                        if (!guarded(guard, addr)) begin // see [RULE_22] [RULE_25]
                            next_memWr.strobe = 1'b1;
                            next_memWr.addr = addr;
                            next_memWr.data = byteIn;
                        end
                        next_wroteData = 1'b1;
                        next_addr = addr + 17'h1;
                    end
                end
                snp_pkg::SNP_READ: begin
                    if (bitCnt == 3'h7) begin
                        next_addr = addr + 17'h1;
                        next_memRdReq = 1'b1;
                        next_memRdAddr = addr + 17'h1;
                    end
                end
                default: begin
                end
            endcase
        end else if (sckFall) begin
            if (state == snp_pkg::SNP_STATUS_OUT) begin
                next_misoOe = 1'b1;
                next_miso = shiftOut[7];
                next_shiftOut = {shiftOut[6:0], shiftOut[7]};
            end else if (state == snp_pkg::SNP_READ) begin
                next_misoOe = 1'b1;
                next_miso = (bitCnt == 3'h0) ? memRdData[7] : shiftOut[7];
                next_shiftOut = (bitCnt == 3'h0) ? {memRdData[6:0], 1'b0} :
                    {shiftOut[6:0], 1'b0};
            end else begin
                next_misoOe = 1'b0; // see [RULE_23]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= snp_pkg::SNP_IDLE;
            shiftIn <= 8'h00;
            bitCnt <= 3'h0;
            byteCnt <= 2'h0;
            opcode <= 8'h00;
            shiftOut <= 8'h00;
            addr <= 17'h00000;
            latch <= 1'b0;
            clearAtRise <= 1'b0;
            guard <= 2'h0;
            pinGuard <= 1'b0;
            spare <= snp_pkg::VOLATILE_RESET;
            wroteData <= 1'b0;
            misoOe <= 1'b0;
            miso <= 1'b0;
            nvCmd <= '0;
            memWr <= '0;
            memRdReq <= 1'b0;
            memRdAddr <= 17'h00000;
            sckPrev <= 1'b0;
            csPrev <= 1'b1;
        end else begin
            state <= next_state;
            shiftIn <= next_shiftIn;
            bitCnt <= next_bitCnt;
            byteCnt <= next_byteCnt;
            opcode <= next_opcode;
            shiftOut <= next_shiftOut;
            addr <= next_addr;
            latch <= next_latch;
            clearAtRise <= next_clearAtRise;
            guard <= next_guard;
            pinGuard <= next_pinGuard;
            spare <= next_spare;
            wroteData <= next_wroteData;
            misoOe <= next_misoOe;
            miso <= next_miso;
            nvCmd <= next_nvCmd;
            memWr <= next_memWr;
            memRdReq <= next_memRdReq;
            memRdAddr <= next_memRdAddr;
            sckPrev <= sck;
            csPrev <= csN;
        end
    end

    assign spiMiso = miso;
    assign spiMisoOe = misoOe;
    assign statusNvCopy = statusNow & snp_pkg::STATUS_NV_MASK;
    assign hwSaveBusyPin = nvBusy;
endmodule // snp_nvram_cmd_protect

// File: snp_spi_master.sv
`timescale 1ns/100ps
module snp_spi_master (
    output logic spiSck,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOe
);
    localparam time HALF = 400ns;
    logic lastSo = 1'b0;
    // A released line shows the inverse of its last bit, so stale data never matches
    wire logic soLine = spiMisoOe ? spiMiso : ~lastSo;

    always @(spiMiso or spiMisoOe) begin
        if (spiMisoOe) begin
            lastSo = spiMiso;
        end
    end

    initial begin
        spiSck = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end

    task automatic open_frame();
        #37 spiCsN = 1'b0;
        #HALF;
    endtask

    // Mode 0; read bits are taken late in the high phase, after the slow sync path
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spiMosi = tx[i];
            #HALF spiSck = 1'b1;
            #HALF rx[i] = soLine;
            spiSck = 1'b0;
        end
    endtask

    task automatic close_frame();
        #HALF spiCsN = 1'b1;
        spiMosi = ~spiMosi;
        #(3 * HALF);
    endtask
endmodule // snp_spi_master

// File: snp_nvram_cmd_protect_checker.sv
`timescale 1ns/100ps
module snp_nvram_cmd_protect_checker #(
    parameter int ADDR_BYTES = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spiCsN,
    input wire logic spiMisoOe,
    input wire logic nvBusy,
    input wire logic nvStatusLoad,
    input wire logic [7:0] statusNvCopy,
    input wire snp_pkg::snp_nv_cmd_s nvCmd,
    input wire snp_pkg::snp_mem_wr_s memWr,
    input wire logic memRdReq,
    input wire logic hwSaveBusyPin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    function automatic logic guarded(input logic [1:0] g, input logic [16:0] x);
        return g == 2'b11 || (g == 2'b10 && x[16]) || (g == 2'b01 && x[16:15] == 2'b11);
    endfunction

    sequence deselected;
        spiCsN [*8];
    endsequence

    sequence quiet;
        (spiCsN && !nvStatusLoad) [*8];
    endsequence

    a_nv_onehot: assert property ($onehot0(nvCmd))
        else $error("several nonvolatile commands at once");
    a_nv_pulse: assert property (nvCmd != '0 |=> nvCmd == '0)
        else $error("nonvolatile command longer than one clock");
    a_strobe_pulse: assert property (memWr.strobe |=> !memWr.strobe)
        else $error("write strobe longer than one clock");
    a_read_pulse: assert property (memRdReq |=> !memRdReq)
        else $error("read request longer than one clock");
    a_busy_pin: assert property ($stable(nvBusy) [*4] |-> hwSaveBusyPin == nvBusy)
        else $error("busy pin does not follow busy");
    a_idle_quiet: assert property (deselected |-> !memWr.strobe && !memRdReq && nvCmd == '0)
        else $error("activity while deselected");
    a_idle_float: assert property (deselected |-> !spiMisoOe)
        else $error("serial out driven while deselected");
    a_guard_block: assert property (memWr.strobe |-> !guarded(statusNvCopy[3:2], memWr.addr))
        else $error("write strobe into guarded range");
    a_status_hold: assert property (quiet |-> $stable(statusNvCopy))
        else $error("status changed without a command");
endmodule // snp_nvram_cmd_protect_checker

bind snp_nvram_cmd_protect snp_nvram_cmd_protect_checker #(.ADDR_BYTES(ADDR_BYTES)) checker_inst (
    .clk(clk), .resetn(resetn), .spiCsN(spiCsN), .spiMisoOe(spiMisoOe), .nvBusy(nvBusy),
    .nvStatusLoad(nvStatusLoad), .statusNvCopy(statusNvCopy), .nvCmd(nvCmd), .memWr(memWr),
    .memRdReq(memRdReq), .hwSaveBusyPin(hwSaveBusyPin)
);

// File: snp_nvram_cmd_protect_tb.sv
`timescale 1ns/100ps
module snp_nvram_cmd_protect_tb;
    localparam time DLY = 5ns;
    logic clk, resetn, nvBusy, nvStatusLoad, writeGuardN, memRdReq, hwSaveBusyPin, oeSeen;
    logic spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic [7:0] nvStatusImage, statusNvCopy, memRdData, s, wrData;
    logic [16:0] memRdAddr, rdAddr, wrAddr, a, b;
    snp_pkg::snp_nv_cmd_s nvCmd, nvSeen;
    snp_pkg::snp_mem_wr_s memWr;
    int errCount = 0;
    int checkCount = 0;
    int wrCount;
    int rdCount;
    logic [7:0] ops [4] = '{snp_pkg::OP_SOFT_SAVE, snp_pkg::OP_SOFT_RESTORE,
        snp_pkg::OP_AUTOSAVE_ON, snp_pkg::OP_AUTOSAVE_OFF};
    logic [16:0] bases [3] = '{17'h0ffff, 17'h17fff, 17'h1ffff};

    always #50 clk = ~clk;

    snp_nvram_cmd_protect snp_nvram_cmd_protect_inst (
        .clk(clk), .resetn(resetn), .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .writeGuardN(writeGuardN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .nvBusy(nvBusy),
        .nvStatusImage(nvStatusImage), .nvStatusLoad(nvStatusLoad), .statusNvCopy(statusNvCopy),
        .nvCmd(nvCmd), .memWr(memWr), .memRdAddr(memRdAddr), .memRdReq(memRdReq),
        .memRdData(memRdData), .hwSaveBusyPin(hwSaveBusyPin)
    );

    snp_spi_master snp_spi_master_inst (
        .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe)
    );

    // Sampled on the falling edge so registered outputs have settled
    always @(negedge clk) begin
        if (memWr.strobe === 1'b1) begin
            wrCount++;
            wrAddr = memWr.addr;
            wrData = memWr.data;
        end
        if (memRdReq === 1'b1) begin
            // The first request of a frame carries the address sent; later ones prefetch
            if (rdCount == 0) begin
                rdAddr = memRdAddr;
            end
            rdCount++;
        end
        if (spiMisoOe === 1'b1) begin
            oeSeen = 1'b1;
        end
        nvSeen = nvSeen | nvCmd;
    end

    function automatic logic hit(input int g, input logic [16:0] x);
        return g == 3 || (g == 2 && x[16]) || (g == 1 && x[16:15] == 2'b11);
    endfunction

    task automatic conclude();
        if (errCount == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] tx [$], output logic [7:0] rx);
        snp_spi_master_inst.open_frame();
        foreach (tx[i]) begin
            snp_spi_master_inst.xfer(tx[i], rx);
        end
        snp_spi_master_inst.close_frame();
    endtask

    task automatic cmd(input logic [7:0] op);
        frame({op}, s);
    endtask

    task automatic setl();
        cmd(snp_pkg::OP_SET_LATCH);
    endtask

    task automatic rds();
        frame({snp_pkg::OP_STATUS_READ, 8'h00}, s);
    endtask

    task automatic wrs(input logic [7:0] d);
        frame({snp_pkg::OP_STATUS_WRITE, d}, s);
    endtask

    task automatic pins(input logic guardN, input logic busy);
        @(posedge clk);
        #DLY writeGuardN = guardN;
        nvBusy = busy;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        errCount++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        nvBusy = 1'b0;
        writeGuardN = 1'b1;
        nvStatusImage = 8'h00;
        nvStatusLoad = 1'b0;
        // Not a bit palindrome, so a reversed shift order shows up
        memRdData = 8'h35;
        nvSeen = '0;
        oeSeen = 1'b0;
        wrCount = 0;
        rdCount = 0;
        repeat (5) @(posedge clk);
        #DLY resetn = 1'b1;
        repeat (8) @(posedge clk);
        rds();
        chk(s, 8'h00, "reset status");
        wrs(8'h8c);
        rds();
        chk(s, 8'h00, "write without latch");
        setl();
        rds();
        chk(s, 8'h02, "latch set");
        cmd(snp_pkg::OP_CLEAR_LATCH);
        rds();
        chk(s, 8'h00, "latch clear");
        setl();
        wrs(8'h8f);
        rds();
        chk(s, 8'h8c, "status write");
        chk(statusNvCopy, 8'h8c, "save copy");
        pins(1'b0, 1'b0);
        setl();
        wrs(8'h00);
        rds();
        chk(s & 8'hfd, 8'h8c, "guard pin refuses");
        pins(1'b1, 1'b0);
        setl();
        wrs(8'h00);
        rds();
        chk(s, 8'h00, "guard pin high");
        pins(1'b0, 1'b0);
        setl();
        wrs(8'h04);
        rds();
        chk(s, 8'h04, "guard pin ignored");
        pins(1'b1, 1'b0);
        for (int g = 0; g < 4; g++) begin
            setl();
            wrs({4'h0, 2'(g), 2'b00});
            foreach (bases[k]) begin
                a = bases[k];
                b = a + 17'h1;
                wrCount = 0;
                setl();
                frame({snp_pkg::OP_MEM_WRITE, 8'(a[16]), a[15:8], a[7:0], 8'h50, 8'ha5}, s);
                chk(wrCount, !hit(g, a) + !hit(g, b), "strobe count");
                if (!hit(g, b)) begin
                    chk(wrAddr, b, "burst address");
                    chk(wrData, 8'ha5, "burst data");
                end
            end
        end
        foreach (ops[k]) begin
            nvSeen = '0;
            cmd(ops[k]);
            chk(nvSeen, 4'h0, "command without latch");
            setl();
            cmd(ops[k]);
            chk(nvSeen, 4'h8 >> k, "nonvolatile command");
            rds();
            chk(s, 8'h0c, "latch auto clear");
        end
        pins(1'b1, 1'b1);
        rds();
        chk(s, 8'h0d, "busy flag");
        chk(hwSaveBusyPin, 1'b1, "busy pin");
        pins(1'b1, 1'b0);
        oeSeen = 1'b0;
        frame({snp_pkg::OP_RESERVED, 8'h00, 8'h00}, s);
        chk(oeSeen, 1'b0, "reserved opcode");
        rdCount = 0;
        frame({snp_pkg::OP_MEM_READ, 8'h01, 8'h23, 8'h45, 8'h00}, s);
        chk(rdAddr, 17'h12345, "read address");
        chk(s, 8'h35, "read data");
        setl();
        wrs(8'h70);
        rds();
        chk(s, 8'h70, "spare bits written");
        @(posedge clk);
        #DLY resetn = 1'b0;
        repeat (5) @(posedge clk);
        #DLY resetn = 1'b1;
        repeat (8) @(posedge clk);
        rds();
        chk(s, 8'h00, "spare bits and latch after reset");
        @(posedge clk);
        #DLY nvStatusImage = 8'hff;
        nvStatusLoad = 1'b1;
        @(posedge clk);
        #DLY nvStatusLoad = 1'b0;
        rds();
        chk(s, 8'h8c, "restored status");
        conclude();
    end
endmodule // snp_nvram_cmd_protect_tb
